// *** include/fwp_pkg.sv ***
/*
  fwp_pkg: register map, field positions, reset values, key words and
  address constants of the flash write-protect register block.
  Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
*/
package fwp_pkg;

  // register byte offsets
  localparam logic [7:0] FWP_OFS_CONTROL   = 8'h00;
  localparam logic [7:0] FWP_OFS_KEY       = 8'h04;
  localparam logic [7:0] FWP_OFS_TARGET    = 8'h08;
  localparam logic [7:0] FWP_OFS_SOURCE    = 8'h0C;
  localparam logic [7:0] FWP_OFS_PROG_PROT = 8'h10;
  localparam logic [7:0] FWP_OFS_BOOT_PROT = 8'h14;
  localparam logic [7:0] FWP_OFS_STATUS    = 8'h18;

  // program-flash protect fields
  localparam int          FWP_PP_UNLOCK_BIT  = 31;
  localparam logic [31:0] FWP_PP_RESET       = 32'h8000_0000;
  localparam logic [7:0]  FWP_PFM_PREFIX     = 8'h1D;

  // boot-alias protect fields
  localparam int          FWP_BP_UNLOCK_BIT  = 15;
  localparam int          FWP_BP_PAGE2_BIT   = 10;
  localparam int          FWP_BP_PAGE1_BIT   = 9;
  localparam int          FWP_BP_PAGE0_BIT   = 8;
  localparam logic [31:0] FWP_BP_RESET       = 32'h0000_8700;
  localparam logic [31:0] FWP_BOOT_PAGE2_BASE = 32'h1FC0_0000;
  localparam logic [31:0] FWP_BOOT_PAGE1_BASE = 32'h1FC0_0800;
  localparam logic [31:0] FWP_BOOT_PAGE0_BASE = 32'h1FC0_1000;
  localparam logic [31:0] FWP_PAGE_MASK       = 32'hFFFF_F800;

  // control register fields
  localparam int          FWP_CTL_START_BIT  = 15;
  localparam int          FWP_CTL_ERR_BIT    = 13;
  localparam logic [3:0]  FWP_OP_NONE        = 4'h0;
  localparam logic [3:0]  FWP_OP_DWORD       = 4'h2;
  localparam logic [3:0]  FWP_OP_ROW         = 4'h3;
  localparam logic [3:0]  FWP_OP_PAGE_ERASE  = 4'h4;

  // unlock key words
  localparam logic [31:0] FWP_KEY_FIRST      = 32'hAA99_6655;
  localparam logic [31:0] FWP_KEY_SECOND     = 32'h5566_99AA;

  // key sequence states
  typedef enum logic [1:0] {
    FWP_KEY_IDLE = 2'b00,
    FWP_KEY_HALF = 2'b01,
    FWP_KEY_OPEN = 2'b10
  } fwp_key_type;

  // request handed to the flash engine
  typedef struct packed {
    logic        valid;
    logic [3:0]  op;
    logic [31:0] target;
    logic [31:0] source;
  } fwp_req_type;

endpackage

// *** rtl/fwp_regs.sv ***
/*
  fwp_regs: flash controller register logic with program-flash and
  boot-alias page write protection, key unlock sequence and row source.
  Assumes a classic Wishbone master on clk_i and a flash engine that
  only runs requests raised on req_o.
*/
// Operation
// - source address register holds 32-bit address
// - program unlock bit 31 gates threshold writes
// - unlock bits clear-only, set by reset
// - threshold changes only while program unlocked
// - addresses below 0x1D threshold are protected
// - zero threshold disables program protection
// - threshold page and lower pages protected
// - boot unlock bit 15 gates page bits
// - boot page bits change only while unlocked
// - bit 10 protects 0x1FC00000-0x1FC007FF
// - bit 9 protects 0x1FC00800-0x1FC00FFF
// - bit 8 protects 0x1FC01000-0x1FC017FF
// - bits 30-24 ignore writes, read zero
// - op 0011 programs row if unprotected
// - page erase ignores address bits 10:0
`timescale 1ns/1ns
module fwp_regs (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output fwp_pkg::fwp_req_type      req_o
);

  // whole-page protection test against threshold and boot bits
  function automatic logic page_locked(input logic [31:0] adr,
                                       input logic [23:0] thr,
                                       input logic [2:0]  boot);
    logic [31:0] pg;
    logic [31:0] lim;
    pg  = adr & fwp_pkg::FWP_PAGE_MASK;
    lim = {fwp_pkg::FWP_PFM_PREFIX, thr};
    page_locked = 1'b0;
    if (thr != 24'h00_0000 && adr[31:24] == fwp_pkg::FWP_PFM_PREFIX
        && pg <= lim)
      page_locked = 1'b1;
    if (pg == fwp_pkg::FWP_BOOT_PAGE2_BASE && boot[2])
      page_locked = 1'b1;
    if (pg == fwp_pkg::FWP_BOOT_PAGE1_BASE && boot[1])
      page_locked = 1'b1;
    if (pg == fwp_pkg::FWP_BOOT_PAGE0_BASE && boot[0])
      page_locked = 1'b1;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    merge = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        merge[i*8 +: 8] = wd[i*8 +: 8];
  endfunction

  logic [31:0]              source_q;
  logic [31:0]              target_q;
  logic [3:0]               op_q;
  logic                     err_q;
  logic                     pp_unlock;
  logic [23:0]              pp_thr;
  logic                     bp_unlock;
  logic [2:0]               bp_pages;
  fwp_pkg::fwp_key_type     key_state;
  fwp_pkg::fwp_req_type     req_q;
  logic [31:0]              rdata_q;
  logic                     ack_q;

  logic [31:0]              next_source;
  logic [31:0]              next_target;
  logic [3:0]               next_op;
  logic                     next_err;
  logic                     next_pp_unlock;
  logic [23:0]              next_pp_thr;
  logic                     next_bp_unlock;
  logic [2:0]               next_bp_pages;
  fwp_pkg::fwp_key_type     next_key_state;
  fwp_pkg::fwp_req_type     next_req;
  logic [31:0]              next_rdata;
  logic                     next_ack;

  logic                     acc;
  logic                     wr;
  logic [31:0]              wv;
  logic                     op_locked;

  // one access per request; ack drops the cycle after it rises
  assign acc = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr  = acc && wb_we_i;
  assign op_locked = page_locked(target_q, pp_thr, bp_pages);

  // next state of registers, key sequence and flash request
  always_comb
  begin
    next_source    = source_q;
    next_target    = target_q;
    next_op        = op_q;
    next_err       = err_q;
    next_pp_unlock = pp_unlock;
    next_pp_thr    = pp_thr;
    next_bp_unlock = bp_unlock;
    next_bp_pages  = bp_pages;
    next_key_state = key_state;
    next_req       = '0;
    next_rdata     = 32'h0000_0000;
    next_ack       = acc;
    wv             = 32'h0000_0000;
    // any access other than the key walk drops an open unlock
    if (acc && !(wr && wb_adr_i == fwp_pkg::FWP_OFS_KEY))
      next_key_state = fwp_pkg::FWP_KEY_IDLE;
    if (wr)
    begin
      unique case (wb_adr_i)
        fwp_pkg::FWP_OFS_KEY:
        begin
          // two key words open one protected write
          if (key_state == fwp_pkg::FWP_KEY_IDLE && wb_dat_i == fwp_pkg::FWP_KEY_FIRST)
            next_key_state = fwp_pkg::FWP_KEY_HALF;
          else if (key_state == fwp_pkg::FWP_KEY_HALF
                   && wb_dat_i == fwp_pkg::FWP_KEY_SECOND)
            next_key_state = fwp_pkg::FWP_KEY_OPEN;
          else
            next_key_state = fwp_pkg::FWP_KEY_IDLE;
        end
        fwp_pkg::FWP_OFS_TARGET:
          next_target = merge(target_q, wb_dat_i, wb_sel_i);
        fwp_pkg::FWP_OFS_SOURCE:
          next_source = merge(source_q, wb_dat_i, wb_sel_i);
        fwp_pkg::FWP_OFS_PROG_PROT:
        begin
          wv = merge({pp_unlock, 7'h00, pp_thr}, wb_dat_i, wb_sel_i);
          // ignored unless the key walk just finished
          if (key_state == fwp_pkg::FWP_KEY_OPEN && pp_unlock)
          begin
            // locked register keeps all; 30-24 dropped
            next_pp_thr = wv[23:0];
            next_pp_unlock = wv[fwp_pkg::FWP_PP_UNLOCK_BIT];
          end
        end
        fwp_pkg::FWP_OFS_BOOT_PROT:
        begin
          wv = merge({16'h0000, bp_unlock, 4'h0, bp_pages, 8'h00}, wb_dat_i, wb_sel_i);
          if (key_state == fwp_pkg::FWP_KEY_OPEN && bp_unlock)
          begin
            // page bits follow only while unlocked
            next_bp_pages = wv[fwp_pkg::FWP_BP_PAGE2_BIT:fwp_pkg::FWP_BP_PAGE0_BIT];
            next_bp_unlock = wv[fwp_pkg::FWP_BP_UNLOCK_BIT];
          end
        end
        fwp_pkg::FWP_OFS_CONTROL:
        begin
          next_op = wb_dat_i[3:0];
          if (wb_dat_i[fwp_pkg::FWP_CTL_START_BIT])
          begin
            if (wb_dat_i[3:0] == fwp_pkg::FWP_OP_NONE)
              next_err = 1'b0;
            // refuse a protected target, flag the error
            else if (op_locked)
              next_err = 1'b1;
            else
            begin
              next_req.valid  = 1'b1;
              next_req.op     = wb_dat_i[3:0];
              next_req.source = source_q;
              // page erase uses the page base
              if (wb_dat_i[3:0] == fwp_pkg::FWP_OP_PAGE_ERASE)
                next_req.target = target_q & fwp_pkg::FWP_PAGE_MASK;
              else
                next_req.target = target_q;
            end
          end
        end
        default: ;
      endcase
    end
    else if (acc)
    begin
      unique case (wb_adr_i)
        fwp_pkg::FWP_OFS_CONTROL:   next_rdata = {18'h0, err_q, 9'h0, op_q};
        fwp_pkg::FWP_OFS_TARGET:    next_rdata = target_q;
        fwp_pkg::FWP_OFS_SOURCE:    next_rdata = source_q;
        fwp_pkg::FWP_OFS_PROG_PROT: next_rdata = {pp_unlock, 7'h00, pp_thr};
        fwp_pkg::FWP_OFS_BOOT_PROT:
          next_rdata = {16'h0000, bp_unlock, 4'h0, bp_pages, 8'h00};
        fwp_pkg::FWP_OFS_STATUS:    next_rdata = {31'h0, op_locked};
        default:                    next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // registers; reset returns both unlock bits to one
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      source_q  <= 32'h0000_0000;
      target_q  <= 32'h0000_0000;
      op_q      <= 4'h0;
      err_q     <= 1'b0;
      pp_unlock <= fwp_pkg::FWP_PP_RESET[31];
      pp_thr    <= fwp_pkg::FWP_PP_RESET[23:0];
      bp_unlock <= fwp_pkg::FWP_BP_RESET[15];
      bp_pages  <= fwp_pkg::FWP_BP_RESET[10:8];
      key_state <= fwp_pkg::FWP_KEY_IDLE;
      req_q     <= '0;
      rdata_q   <= 32'h0000_0000;
      ack_q     <= 1'b0;
    end
    else
    begin
      source_q  <= next_source;
      target_q  <= next_target;
      op_q      <= next_op;
      err_q     <= next_err;
      pp_unlock <= next_pp_unlock;
      pp_thr    <= next_pp_thr;
      bp_unlock <= next_bp_unlock;
      bp_pages  <= next_bp_pages;
      key_state <= next_key_state;
      req_q     <= next_req;
      rdata_q   <= next_rdata;
      ack_q     <= next_ack;
    end
  end

  assign wb_dat_o = rdata_q;
  assign wb_ack_o = ack_q;
  assign req_o    = req_q;

  // an unlock bit never rises outside reset
  a_pp_unlock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(pp_unlock) |-> $past(rst_i)) else $error("program unlock bit set by write");

  a_bp_unlock_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    !bp_unlock |=> !bp_unlock) else $error("boot unlock bit set again");

  a_thr_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    !pp_unlock |=> $stable(pp_thr)) else $error("threshold changed while locked");

  a_boot_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    !bp_unlock |=> $stable(bp_pages)) else $error("boot pages changed while locked");

  sequence s_no_key;
    key_state != fwp_pkg::FWP_KEY_OPEN;
  endsequence
  // protect write without key leaves threshold
  a_key_needed: assert property (@(posedge clk_i) disable iff (rst_i)
    s_no_key ##0 (wr && wb_adr_i == fwp_pkg::FWP_OFS_PROG_PROT) |=> $stable(pp_thr))
    else $error("protect write taken without key");

  a_pp_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    (acc && !wb_we_i && wb_adr_i == fwp_pkg::FWP_OFS_PROG_PROT) |=> rdata_q[30:24] == 7'h00)
    else $error("program protect reserved bits nonzero");

  // no request for a locked target
  a_refuse_locked: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && wb_adr_i == fwp_pkg::FWP_OFS_CONTROL && op_locked) |=> !req_q.valid)
    else $error("operation issued on protected page");

  // zero threshold never locks program flash
  a_zero_open: assert property (@(posedge clk_i) disable iff (rst_i)
    (pp_thr == 24'h0 && target_q[31:24] == fwp_pkg::FWP_PFM_PREFIX) |-> !op_locked)
    else $error("zero threshold still protects");

  a_erase_align: assert property (@(posedge clk_i) disable iff (rst_i)
    (req_q.valid && req_q.op == fwp_pkg::FWP_OP_PAGE_ERASE) |-> req_q.target[10:0] == 11'h0)
    else $error("erase target not page aligned");

endmodule // fwp_regs

// *** testbench/testbench.sv ***
/*
  testbench: self-checking bench for fwp_regs, register tests over classic Wishbone.
  Assumes fwp_pkg is compiled first and the flash engine is only observed on req_o.
*/
`timescale 1ns/1ns
module testbench;
  logic                 clk_i;
  logic                 rst_i;
  logic                 wb_cyc_i;
  logic                 wb_stb_i;
  logic                 wb_we_i;
  logic [7:0]           wb_adr_i;
  logic [3:0]           wb_sel_i;
  logic [31:0]          wb_dat_i;
  logic [31:0]          wb_dat_o;
  logic                 wb_ack_o;
  fwp_pkg::fwp_req_type req_o;
  fwp_pkg::fwp_req_type req_cap;
  logic                 req_seen;
  logic [31:0]          rd;
  int                   errors;
  int                   checked;
  int                   cycles;

  fwp_regs u_fwp_regs (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .req_o    (req_o)
  );

  // free-running clock, 4 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // catch the one-cycle request pulse so tests can look at it later
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (req_o.valid === 1'b1)
    begin
      req_seen <= 1'b1;
      req_cap  <= req_o;
    end
    if (cycles == 4000)
    begin
      errors = errors + 1;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one classic cycle; waits for ack, no fixed latency assumed
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= wd;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h00000000);
    chk(rd, exp);
  endtask

  // key walk; the key words must directly precede the protect write
  task automatic kwrite(input logic [7:0] adr, input logic [31:0] wd);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_KEY, fwp_pkg::FWP_KEY_FIRST);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_KEY, fwp_pkg::FWP_KEY_SECOND);
    wb_xfer(1'b1, adr, wd);
  endtask

  task automatic lock_chk(input logic [31:0] tgt, input logic [31:0] exp);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_TARGET, tgt);
    rchk(fwp_pkg::FWP_OFS_STATUS, exp);
  endtask

  task automatic start(input logic [3:0] op);
    req_seen = 1'b0;
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_CONTROL, {16'h0000, 12'h800, op});
    repeat (3) @(posedge clk_i);
  endtask

  task automatic do_reset();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h00000000;
    req_seen = 1'b0;
    req_cap = '0;
    errors = 0;
    checked = 0;
    cycles = 0;
    do_reset();
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000000);
    rchk(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00008700);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_SOURCE, 32'h12345678);
    rchk(fwp_pkg::FWP_OFS_SOURCE, 32'h12345678);
    rchk(8'h3C, 32'h00000000);
    $display("test reset_and_source done");
    lock_chk(32'h1D000000, 32'h00000000);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000010);
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000000);
    kwrite(fwp_pkg::FWP_OFS_PROG_PROT, 32'hFF000010);
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000010);
    lock_chk(32'h1D000000, 32'h00000001);
    lock_chk(32'h1D0007FF, 32'h00000001);
    lock_chk(32'h1D000800, 32'h00000000);
    $display("test program_threshold done");
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_TARGET, 32'h1D000010);
    start(fwp_pkg::FWP_OP_ROW);
    chk({31'h0, req_seen}, 32'h00000000);
    rchk(fwp_pkg::FWP_OFS_CONTROL, 32'h00002003);
    start(fwp_pkg::FWP_OP_NONE);
    rchk(fwp_pkg::FWP_OFS_CONTROL, 32'h00000000);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_TARGET, 32'h1D000800);
    start(fwp_pkg::FWP_OP_ROW);
    chk({31'h0, req_seen}, 32'h00000001);
    chk({28'h0, req_cap.op}, 32'h00000003);
    chk(req_cap.target, 32'h1D000800);
    chk(req_cap.source, 32'h12345678);
    wb_xfer(1'b1, fwp_pkg::FWP_OFS_TARGET, 32'h1D000C34);
    start(fwp_pkg::FWP_OP_PAGE_ERASE);
    chk({31'h0, req_seen}, 32'h00000001);
    chk({28'h0, req_cap.op}, 32'h00000004);
    chk(req_cap.target, 32'h1D000800);
    $display("test row_program done");
    kwrite(fwp_pkg::FWP_OFS_PROG_PROT, 32'h00000010);
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h00000010);
    kwrite(fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000040);
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h00000010);
    $display("test program_lock done");
    kwrite(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00008300);
    rchk(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00008300);
    lock_chk(32'h1FC007FF, 32'h00000000);
    lock_chk(32'h1FC00800, 32'h00000001);
    lock_chk(32'h1FC017FF, 32'h00000001);
    kwrite(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00000000);
    lock_chk(32'h1FC00FFF, 32'h00000000);
    lock_chk(32'h1FC01000, 32'h00000000);
    kwrite(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00008700);
    rchk(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00000000);
    $display("test boot_alias done");
    do_reset();
    rchk(fwp_pkg::FWP_OFS_PROG_PROT, 32'h80000000);
    rchk(fwp_pkg::FWP_OFS_BOOT_PROT, 32'h00008700);
    $display("test second_reset done");
    wrap_up();
  end
endmodule // testbench
